// ---- modbus_pdu_map.vh ----
`ifndef MODBUS_PDU_MAP_VH
`define MODBUS_PDU_MAP_VH

// ----------------------------------------------------------------------------
// Function codes
// ----------------------------------------------------------------------------
`define FC_READ_COILS     8'h01
`define FC_READ_DISCRETE  8'h02
`define FC_READ_HOLDING   8'h03
`define FC_READ_INPUT     8'h04
`define FC_WRITE_COIL     8'h05
`define FC_EXC_FLAG       8'h80

// ----------------------------------------------------------------------------
// Exception codes
// ----------------------------------------------------------------------------
`define EXC_NONE          8'h00
`define EXC_BAD_FUNCTION  8'h01
`define EXC_BAD_ADDRESS   8'h02
`define EXC_BAD_VALUE     8'h03

// ----------------------------------------------------------------------------
// Limits and field values
// ----------------------------------------------------------------------------
`define MAX_BIT_ITEMS     16'h07D0
`define MAX_REG_ITEMS     16'h007D
`define COIL_ON_VALUE     16'hFF00
`define COIL_OFF_VALUE    16'h0000
`define REQ_FIELD_BYTES   3'h5
`define ADDR_SPACE_END    17'h10000

`endif

// ---- modbus_pdu_server.v ----
`timescale 1ns/1ps
`include "modbus_pdu_map.vh"

// ----------------------------------------------------------------------------
// Response FIFO
// ----------------------------------------------------------------------------
module byte_fifo #(
  parameter WIDTH = 9,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire             clk_in,
  input  wire             srst_in,
  input  wire             in_valid_in,
  input  wire [WIDTH-1:0] in_data_in,
  output wire             in_ready_out,
  output wire             out_valid_out,
  output wire [WIDTH-1:0] out_data_out,
  input  wire             out_ready_in
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wp;
  reg [AW-1:0]    rp;
  reg [AW:0]      count;
  wire            push;
  wire            pop;

  assign in_ready_out  = (count != DEPTH[AW:0]);
  assign out_valid_out = (count != {(AW+1){1'b0}});
  assign out_data_out  = mem[rp];
  assign push          = in_valid_in & in_ready_out;
  assign pop           = out_valid_out & out_ready_in;

  always @(posedge clk_in)
  begin
    if (push)
    begin
      mem[wp] <= in_data_in;
    end
    if (srst_in)
    begin
      wp    <= {AW{1'b0}};
      rp    <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
    end
    else
    begin
      if (push)
      begin
        wp <= (wp == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wp + 1'b1;
      end
      if (pop)
      begin
        rp <= (rp == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rp + 1'b1;
      end
      if (push & ~pop)
      begin
        count <= count + 1'b1;
      end
      else if (pop & ~push)
      begin
        count <= count - 1'b1;
      end
    end
  end
endmodule // byte_fifo

// Function
// [RQ1] Bit reads carry code, 2-byte start and 2-byte quantity 1 to 2000.
// [RQ2] Codes 0x01 and 0x02 read coils and discrete inputs, echoed in reply.
// [RQ3] Bit reply gives count (N+7)/8 then packed status bytes, first eight first.
// [RQ4] Unused high bits of the last status byte are zero.
// [RQ5] Lowest address sits in the least significant bit, rising toward the top.
// [RQ6] Failed bit read answers code plus 0x80 and one exception byte.
// [RQ7] Every exception reply carries one code byte from 0x01 to 0x04.
// [RQ8] Codes 0x03 and 0x04 read holding and input registers, echoed.
// [RQ9] Register reads carry 2-byte start and count of at most 125.
// [RQ10] Register reply gives count 2N then words high byte first, ascending.
// [RQ11] Failed register read answers 0x83 or 0x84 and one exception byte.
// [RQ12] Code 0x05 writes one coil; reply echoes code, address and value.
// [RQ13] Client sends 0xFF00 for on and 0x0000 for off.
// [RQ14] Written coil is active when the echoed value is non-zero.
// [RQ15] Failed coil write answers 0x85 and one exception byte.
// [RQ16] Every 2-byte field travels most significant byte first.
// [RQ17] Multi-byte values are big-endian, 0x1234 as 0x12 then 0x34.
// [RQ18] Zero or over-limit quantity gets an exception instead of a reply.
module modbus_pdu_server #(
  parameter FIFO_DEPTH = 16,
  parameter FIFO_AW    = 4
) (
  input  wire        clk_in,
  input  wire        srst_in,
  input  wire        req_valid_in,
  input  wire [7:0]  req_data_in,
  input  wire        req_last_in,
  output wire        req_ready_out,
  output wire        rsp_valid_out,
  output wire [7:0]  rsp_data_out,
  output wire        rsp_last_out,
  input  wire        rsp_ready_in,
  output reg         rd_en_out,
  output reg  [1:0]  rd_space_out,
  output reg  [15:0] rd_addr_out,
  input  wire [15:0] rd_data_in,
  output reg         coil_wr_out,
  output reg  [15:0] coil_addr_out,
  output reg         coil_value_out
);
  // --------------------------------------------------------------------------
  // State encoding
  // --------------------------------------------------------------------------
  localparam S_RX    = 9'h001;
  localparam S_CHK   = 9'h002;
  localparam S_EXC   = 9'h004;
  localparam S_ECHO  = 9'h008;
  localparam S_HDR   = 9'h010;
  localparam S_FETCH = 9'h020;
  localparam S_WAIT  = 9'h040;
  localparam S_GOT   = 9'h080;
  localparam S_PUSH  = 9'h100;

  reg  [8:0]  state;
  reg  [7:0]  fc;
  reg  [15:0] addr;
  reg  [15:0] qty;
  reg  [2:0]  rx_cnt;
  reg  [2:0]  cnt;
  reg  [7:0]  exc;
  reg  [15:0] item;
  reg  [7:0]  acc;
  reg  [2:0]  bpos;
  reg  [15:0] word;
  reg  [7:0]  next_exc;
  reg  [7:0]  push_data;
  reg         push_last;
  wire        push_valid;
  wire        push_ready;
  wire        is_bit;
  wire        is_reg;
  wire [16:0] span_end;
  wire [16:0] bit_bytes;
  wire [15:0] next_item;

  assign is_bit     = (fc == `FC_READ_COILS) | (fc == `FC_READ_DISCRETE);
  assign is_reg     = (fc == `FC_READ_HOLDING) | (fc == `FC_READ_INPUT);
  assign span_end   = {1'b0, addr} + {1'b0, qty};
  assign bit_bytes  = ({1'b0, qty} + 17'h00007) >> 3;
  assign next_item  = item + 16'h0001;
  assign push_valid = (state == S_EXC) | (state == S_ECHO) | (state == S_HDR) | (state == S_PUSH);
  assign req_ready_out = (state == S_RX);

  // --------------------------------------------------------------------------
  // Request checking
  // --------------------------------------------------------------------------
  // Address overflow past the top of the table is reported apart from bad counts.
  always @*
  begin
    // [RQ7] codes stay in range
    next_exc = `EXC_NONE;
    if (~is_bit & ~is_reg & (fc != `FC_WRITE_COIL))
    begin
      next_exc = `EXC_BAD_FUNCTION;
    end
    else if (rx_cnt < `REQ_FIELD_BYTES)
    begin
      next_exc = `EXC_BAD_VALUE;
    end
    // [RQ1] bit count limit
    else if (is_bit & ((qty == 16'h0000) | (qty > `MAX_BIT_ITEMS)))
    begin
      next_exc = `EXC_BAD_VALUE;
    end
    // [RQ18] [RQ9] register count limit
    else if (is_reg & ((qty == 16'h0000) | (qty > `MAX_REG_ITEMS)))
    begin
      next_exc = `EXC_BAD_VALUE;
    end
    // [RQ13] coil value check
    else if ((fc == `FC_WRITE_COIL) & (qty != `COIL_ON_VALUE) & (qty != `COIL_OFF_VALUE))
    begin
      next_exc = `EXC_BAD_VALUE;
    end
    else if ((is_bit | is_reg) & (span_end > `ADDR_SPACE_END))
    begin
      next_exc = `EXC_BAD_ADDRESS;
    end
  end

  // --------------------------------------------------------------------------
  // Response byte selection
  // --------------------------------------------------------------------------
  always @*
  begin
    push_data = 8'h00;
    push_last = 1'b0;
    case (state)
      S_EXC:
      begin
        // [RQ6] [RQ11] [RQ15] flagged code
        push_data = (cnt == 3'h0) ? (fc | `FC_EXC_FLAG) : exc;
        push_last = (cnt == 3'h1);
      end
      S_ECHO:
      begin
        // [RQ12] [RQ16] echo high first
        case (cnt)
          3'h0:    push_data = fc;
          3'h1:    push_data = addr[15:8];
          3'h2:    push_data = addr[7:0];
          3'h3:    push_data = qty[15:8];
          default: push_data = qty[7:0];
        endcase
        push_last = (cnt == 3'h4);
      end
      S_HDR:
      begin
        // [RQ2] [RQ8] [RQ3] [RQ10] code and count
        if (cnt == 3'h0)
        begin
          push_data = fc;
        end
        else if (is_bit)
        begin
          push_data = bit_bytes[7:0];
        end
        else
        begin
          push_data = {qty[6:0], 1'b0};
        end
      end
      S_PUSH:
      begin
        // [RQ10] [RQ17] word high byte first
        if (is_reg)
        begin
          push_data = (cnt == 3'h0) ? word[15:8] : word[7:0];
        end
        else
        begin
          push_data = acc;
        end
        push_last = (item == qty) & (is_bit | (cnt == 3'h1));
      end
      default:
      begin
        push_data = 8'h00;
        push_last = 1'b0;
      end
    endcase
  end

  // --------------------------------------------------------------------------
  // Control
  // --------------------------------------------------------------------------
  always @(posedge clk_in)
  begin
    if (srst_in)
    begin
      state          <= S_RX;
      fc             <= 8'h00;
      addr           <= 16'h0000;
      qty            <= 16'h0000;
      rx_cnt         <= 3'h0;
      cnt            <= 3'h0;
      exc            <= `EXC_NONE;
      item           <= 16'h0000;
      acc            <= 8'h00;
      bpos           <= 3'h0;
      word           <= 16'h0000;
      rd_en_out      <= 1'b0;
      rd_space_out   <= 2'h0;
      rd_addr_out    <= 16'h0000;
      coil_wr_out    <= 1'b0;
      coil_addr_out  <= 16'h0000;
      coil_value_out <= 1'b0;
    end
    else
    begin
      rd_en_out   <= 1'b0;
      coil_wr_out <= 1'b0;
      case (state)
        S_RX:
        begin
          if (req_valid_in)
          begin
            // [RQ16] [RQ17] fields arrive high byte first
            case (rx_cnt)
              3'h0:    fc         <= req_data_in;
              3'h1:    addr[15:8] <= req_data_in;
              3'h2:    addr[7:0]  <= req_data_in;
              3'h3:    qty[15:8]  <= req_data_in;
              3'h4:    qty[7:0]   <= req_data_in;
              default: fc         <= fc;
            endcase
            if (rx_cnt != `REQ_FIELD_BYTES)
            begin
              rx_cnt <= rx_cnt + 3'h1;
            end
            if (req_last_in)
            begin
              state <= S_CHK;
            end
          end
        end
        S_CHK:
        begin
          rx_cnt       <= 3'h0;
          cnt          <= 3'h0;
          item         <= 16'h0000;
          acc          <= 8'h00;
          bpos         <= 3'h0;
          exc          <= next_exc;
          // [RQ18] exception replaces the normal reply
          if (next_exc != `EXC_NONE)
          begin
            state <= S_EXC;
          end
          else if (fc == `FC_WRITE_COIL)
          begin
            // [RQ14] non-zero means active
            coil_wr_out    <= 1'b1;
            coil_addr_out  <= addr;
            coil_value_out <= (qty != 16'h0000);
            state          <= S_ECHO;
          end
          else
          begin
            state <= S_HDR;
          end
        end
        S_EXC, S_ECHO, S_HDR:
        begin
          if (push_ready)
          begin
            cnt <= cnt + 3'h1;
            if (push_last)
            begin
              state <= S_RX;
              cnt   <= 3'h0;
            end
            else if ((state == S_HDR) & (cnt == 3'h1))
            begin
              state <= S_FETCH;
              cnt   <= 3'h0;
            end
          end
        end
        S_FETCH:
        begin
          // [RQ10] [RQ5] ascending addresses
          rd_en_out    <= 1'b1;
          rd_space_out <= fc[1:0] - 2'h1;
          rd_addr_out  <= addr + item;
          state        <= S_WAIT;
        end
        S_WAIT:
        begin
          state <= S_GOT;
        end
        S_GOT:
        begin
          item <= next_item;
          if (is_reg)
          begin
            word  <= rd_data_in;
            state <= S_PUSH;
          end
          else
          begin
            // [RQ5] lowest address in bit 0
            acc  <= acc | ({7'h00, rd_data_in[0]} << bpos);
            bpos <= bpos + 3'h1;
            // [RQ3] eight items per byte
            state <= ((bpos == 3'h7) | (next_item == qty)) ? S_PUSH : S_FETCH;
          end
        end
        S_PUSH:
        begin
          if (push_ready)
          begin
            if (push_last)
            begin
              state <= S_RX;
              cnt   <= 3'h0;
            end
            else if (is_reg & (cnt == 3'h0))
            begin
              cnt <= 3'h1;
            end
            else
            begin
              // [RQ4] fresh byte starts at zero
              acc   <= 8'h00;
              bpos  <= 3'h0;
              cnt   <= 3'h0;
              state <= S_FETCH;
            end
          end
        end
        default:
        begin
          state <= S_RX;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Output buffering
  // --------------------------------------------------------------------------
  // A full FIFO stalls byte generation, so a slow drain never loses a reply byte.
  byte_fifo #(
    .WIDTH (9),
    .DEPTH (FIFO_DEPTH),
    .AW    (FIFO_AW)
  ) u_rsp_fifo (
    .clk_in        (clk_in),
    .srst_in       (srst_in),
    .in_valid_in   (push_valid),
    .in_data_in    ({push_last, push_data}),
    .in_ready_out  (push_ready),
    .out_valid_out (rsp_valid_out),
    .out_data_out  ({rsp_last_out, rsp_data_out}),
    .out_ready_in  (rsp_ready_in)
  );
endmodule // modbus_pdu_server

// ---- modbus_table_model.sv ----
`timescale 1ns/1ps
// Data is valid only in the cycle after a request; at any
// other time it churns so a late sample shows up as a mismatch.
module modbus_table_model (
  input  wire        clk_in,
  input  wire        rd_en_in,
  input  wire [1:0]  space_in,
  input  wire [15:0] addr_in,
  output reg  [15:0] data_out
);
  initial data_out = 16'h0000;
  always @(posedge clk_in)
  begin
    if (rd_en_in)
      data_out <= {addr_in[7:0] ^ 8'h5A, addr_in[15:8] ^ {addr_in[1:0], space_in, addr_in[3:1], addr_in[0] ^ space_in[0]}};
    else
      data_out <= ~data_out;
  end
endmodule // modbus_table_model

// ---- modbus_pdu_server_props.sv ----
`timescale 1ns/1ps
module modbus_pdu_server_props (
  input wire        clk_in,
  input wire        srst_in,
  input wire        req_valid_in,
  input wire [7:0]  req_data_in,
  input wire        req_last_in,
  input wire        req_ready_out,
  input wire        rsp_valid_out,
  input wire [7:0]  rsp_data_out,
  input wire        rsp_last_out,
  input wire        rsp_ready_in,
  input wire        rd_en_out,
  input wire [1:0]  rd_space_out,
  input wire [15:0] rd_addr_out,
  input wire        coil_wr_out,
  input wire [15:0] coil_addr_out,
  input wire        coil_value_out
);
  // Marks the first byte of each reply.
  reg at_start;
  always @(posedge clk_in)
    if (srst_in)
      at_start <= 1'b1;
    else if (rsp_valid_out && rsp_ready_in)
      at_start <= rsp_last_out;

  // Function code of the request being answered, kept for the exception head.
  reg       req_first;
  reg [7:0] req_fc;
  always @(posedge clk_in)
    if (srst_in)
    begin
      req_first <= 1'b1;
      req_fc    <= 8'h00;
    end
    else if (req_valid_in && req_ready_out)
    begin
      if (req_first)
        req_fc <= req_data_in;
      req_first <= req_last_in;
    end

  default clocking @(posedge clk_in); endclocking
  default disable iff (srst_in);

  sequence s_last_taken;
    req_valid_in && req_ready_out && req_last_in;
  endsequence
  sequence s_exc_head;
    at_start && rsp_valid_out && rsp_data_out[7];
  endsequence
  sequence s_exc_tail;
    ##[1:4] (rsp_valid_out && rsp_last_out && rsp_data_out inside {[8'h01:8'h04]});
  endsequence

  a_ready_busy: assert property (s_last_taken |=> !req_ready_out [*2])
    else $error("request taken while busy");
  a_reply_starts: assert property (s_last_taken |-> ##[1:3] rsp_valid_out)
    else $error("no reply after request");
  a_exc_fc_range: assert property (s_exc_head |-> rsp_data_out == (req_fc | 8'h80))
    else $error("bad exception function code");
  a_exc_code_one: assert property (s_exc_head ##0 rsp_ready_in |-> s_exc_tail)
    else $error("bad exception code byte");
  a_head_not_last: assert property (at_start && rsp_valid_out |-> !rsp_last_out)
    else $error("reply of one byte");
  a_rsp_hold: assert property (rsp_valid_out && !rsp_ready_in |=>
    rsp_valid_out && $stable(rsp_data_out) && $stable(rsp_last_out))
    else $error("reply byte changed while stalled");
  a_rd_spacing: assert property (rd_en_out |=> !rd_en_out [*2])
    else $error("table reads too close");
  a_rd_addr_hold: assert property (!rd_en_out |-> $stable(rd_addr_out) && $stable(rd_space_out))
    else $error("read address moved");
  a_coil_pulse: assert property (coil_wr_out |=> !coil_wr_out)
    else $error("coil write longer than one cycle");
  a_coil_hold: assert property (!coil_wr_out |-> $stable(coil_addr_out) && $stable(coil_value_out))
    else $error("coil outputs moved");
endmodule // modbus_pdu_server_props

// ---- modbus_pdu_server_tb_top.sv ----
`timescale 1ns/1ps
module modbus_pdu_server_tb_top;
  reg         clk_in = 1'b0;
  reg         srst_in = 1'b1;
  reg         req_valid_in = 1'b0;
  reg  [7:0]  req_data_in = 8'h00;
  reg         req_last_in = 1'b0;
  reg         rsp_ready_in = 1'b0;
  wire        req_ready_out, rsp_valid_out, rsp_last_out, rd_en_out, coil_wr_out, coil_value_out;
  wire [7:0]  rsp_data_out;
  wire [1:0]  rd_space_out;
  wire [15:0] rd_addr_out, rd_data_in, coil_addr_out;
  int         errors = 0;
  int         checked = 0;
  int         k;
  logic [7:0] got[$], exp[$];
  logic [16:0] wr_seen[$], wr_exp[$];
  bit         done;

  always #10 clk_in = ~clk_in;

  modbus_pdu_server i_modbus_pdu_server (.clk_in(clk_in), .srst_in(srst_in), .req_valid_in(req_valid_in),
    .req_data_in(req_data_in), .req_last_in(req_last_in), .req_ready_out(req_ready_out),
    .rsp_valid_out(rsp_valid_out), .rsp_data_out(rsp_data_out), .rsp_last_out(rsp_last_out),
    .rsp_ready_in(rsp_ready_in), .rd_en_out(rd_en_out), .rd_space_out(rd_space_out),
    .rd_addr_out(rd_addr_out), .rd_data_in(rd_data_in), .coil_wr_out(coil_wr_out),
    .coil_addr_out(coil_addr_out), .coil_value_out(coil_value_out));
  modbus_table_model i_modbus_table_model (.clk_in(clk_in), .rd_en_in(rd_en_out),
    .space_in(rd_space_out), .addr_in(rd_addr_out), .data_out(rd_data_in));

  // Random stalls on the reply side, one cycle in four, let a few bytes queue in the FIFO without filling it.
  always @(posedge clk_in) #1 rsp_ready_in = ($urandom_range(3) != 0);
  always @(posedge clk_in)
  begin
    if (rsp_valid_out === 1'b1 && rsp_ready_in === 1'b1)
    begin
      got.push_back(rsp_data_out);
      if (rsp_last_out === 1'b1) done = 1'b1;
    end
    if (coil_wr_out === 1'b1) wr_seen.push_back({coil_value_out, coil_addr_out});
  end

  task automatic chk(input string nm, input logic [16:0] e, input logic [16:0] g);
    checked++;
    if (g !== e)
    begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic model(input logic [7:0] b[$]);
    int fc, ad, n, ec, i;
    logic [15:0] v;
    logic [7:0] acc;
    logic [1:0] sp;
    fc = b[0];
    ad = b.size() > 2 ? {b[1], b[2]} : 0;
    n = b.size() > 4 ? {b[3], b[4]} : 0;
    ec = 0;
    acc = 8'h00;
    sp = 2'(fc - 1);
    if (fc < 1 || fc > 5) ec = 1;
    else if (b.size() < 5) ec = 3;
    else if (fc == 5 && n != 16'hFF00 && n != 0) ec = 3;
    else if (fc < 5 && (n == 0 || n > (fc < 3 ? 2000 : 125))) ec = 3;
    else if (fc < 5 && ad + n > 32'h10000) ec = 2;
    if (ec != 0) exp = {8'(fc | 8'h80), 8'(ec)};
    else if (fc == 5)
    begin
      exp = b[0:4];
      wr_exp.push_back({n != 0, 16'(ad)});
    end
    else
    begin
      exp = {8'(fc), 8'(fc < 3 ? (n + 7) / 8 : 2 * n)};
      for (i = 0; i < n; i++)
      begin
        v = {ad[7:0] ^ 8'h5A, 8'(ad >> 8) ^ {ad[1:0], sp, ad[3:1], ad[0] ^ sp[0]}};
        ad++;
        if (fc < 3) acc[i % 8] = v[0];
        if (fc > 2) exp = {exp, v[15:8], v[7:0]};
        else if (i % 8 == 7 || i == n - 1)
        begin
          exp.push_back(acc);
          acc = 8'h00;
        end
      end
    end
  endtask

  task automatic run(input logic [7:0] b[$]);
    int i, t;
    model(b);
    done = 0;
    got = {};
    for (i = 0; i < b.size(); i++)
    begin
      req_valid_in = 1'b1;
      req_data_in = b[i];
      req_last_in = (i == b.size() - 1);
      for (t = 0; t < 20 && req_ready_out !== 1'b1; t++) #20;
      if (req_ready_out !== 1'b1) errors++;
      @(posedge clk_in);
      #1;
    end
    req_valid_in = 1'b0;
    req_last_in = 1'b0;
    for (t = 0; t < 8000 && !done; t++) #20;
    if (!done) errors++;
    chk("rsp_len", 17'(exp.size()), 17'(got.size()));
    for (i = 0; i < exp.size(); i++) chk("rsp_byte", 17'(exp[i]), 17'(got[i]));
  endtask

  task finish_test;
    if (errors == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial
  begin
    repeat (60000) @(posedge clk_in);
    errors++;
    finish_test;
  end

  initial
  begin
    void'($urandom(32'hce00));
    repeat (16) @(posedge clk_in);
    #1 srst_in = 1'b0;
    run('{8'h01, 8'h00, 8'h03, 8'h00, 8'h0A});
    run('{8'h02, 8'h00, 8'h10, 8'h00, 8'h08});
    run('{8'h01, 8'h00, 8'h00, 8'h07, 8'hD0});
    run('{8'h01, 8'h00, 8'h00, 8'h07, 8'hD1});
    run('{8'h02, 8'h00, 8'h00, 8'h00, 8'h00});
    run('{8'h03, 8'h12, 8'h34, 8'h00, 8'h03});
    run('{8'h04, 8'hFF, 8'hFE, 8'h00, 8'h02});
    run('{8'h04, 8'hFF, 8'hFF, 8'h00, 8'h02});
    run('{8'h03, 8'h00, 8'h00, 8'h00, 8'h7D});
    run('{8'h03, 8'h00, 8'h00, 8'h00, 8'h7E});
    run('{8'h05, 8'h00, 8'hA5, 8'hFF, 8'h00});
    run('{8'h05, 8'h00, 8'hA5, 8'h00, 8'h00});
    run('{8'h05, 8'h00, 8'h01, 8'h12, 8'h34});
    run('{8'h06, 8'h00, 8'h00, 8'h00, 8'h01});
    run('{8'h2B, 8'h00});
    run('{8'h03, 8'h00, 8'h01});
    run('{8'h01, 8'h00, 8'h04, 8'h00, 8'h03, 8'hFF, 8'hEE});
    for (k = 0; k < 8; k++)
      run('{8'($urandom_range(5, 1)), 8'($urandom), 8'($urandom), 8'h00, 8'($urandom_range(40, 1))});
    chk("coil_writes", 17'(wr_exp.size()), 17'(wr_seen.size()));
    for (k = 0; k < wr_exp.size(); k++) chk("coil_write", wr_exp[k], wr_seen[k]);
    finish_test;
  end
endmodule // modbus_pdu_server_tb_top

bind modbus_pdu_server modbus_pdu_server_props i_modbus_pdu_server_props (.clk_in(clk_in), .srst_in(srst_in),
  .req_valid_in(req_valid_in), .req_data_in(req_data_in), .req_last_in(req_last_in), .req_ready_out(req_ready_out),
  .rsp_valid_out(rsp_valid_out), .rsp_data_out(rsp_data_out), .rsp_last_out(rsp_last_out),
  .rsp_ready_in(rsp_ready_in), .rd_en_out(rd_en_out), .rd_space_out(rd_space_out), .rd_addr_out(rd_addr_out),
  .coil_wr_out(coil_wr_out), .coil_addr_out(coil_addr_out), .coil_value_out(coil_value_out));
